// file: hdl/brs_recirc_select.sv
`timescale 1ns/10ps
`include "brs_cfg.svh"

module brs_recirc_select #(
	parameter int FILT_CYC = `BRS_ZC_FILT_CYC
) (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic [1:0] recirc_path_select_i,
	input  wire logic       degauss_comp_enable_i,
	input  wire logic       commutate_i,
	input  wire logic [2:0] step_i,
	input  wire logic       pwm_on_i,
	input  wire logic       zc_cmp_i,
	input  wire logic       rail_clamp_i,
	output logic [2:0]      gate_high_o,
	output logic [2:0]      gate_low_o,
	output logic            zc_event_o,
	output logic            recirc_high_o,
	output logic            recirc_low_o
);

	////////////////////////////////////////////////////////////////
	// Commutation table and expected bemf direction
	function automatic brs_pkg::brs_phase_t step_phases(input logic [2:0] step);
		brs_pkg::brs_phase_t p;
		p = '0;
		case (step)
			3'h0: p = '{hi: 3'h1, lo: 3'h2, fl: 3'h4};
			3'h1: p = '{hi: 3'h1, lo: 3'h4, fl: 3'h2};
			3'h2: p = '{hi: 3'h2, lo: 3'h4, fl: 3'h1};
			3'h3: p = '{hi: 3'h2, lo: 3'h1, fl: 3'h4};
			3'h4: p = '{hi: 3'h4, lo: 3'h1, fl: 3'h2};
			3'h5: p = '{hi: 3'h4, lo: 3'h2, fl: 3'h1};
			default: p = '0;
		endcase
		return p;
	endfunction

	function automatic logic bemf_rising(input logic [2:0] step);
		return step[0];
	endfunction

	////////////////////////////////////////////////////////////////
	brs_pkg::brs_state_t st;
	brs_pkg::brs_state_t next_st;
	brs_pkg::brs_phase_t ph;
	brs_pkg::brs_side_t  mixed_side;
	logic                rising;
	logic                sample_en;
	logic                filt_level;
	logic                zc_detect;

	assign ph        = step_phases(step_i);
	assign rising    = bemf_rising(step_i);
	assign sample_en = !(degauss_comp_enable_i && st.degauss);

	brs_zc_filter #(
		.FILT_CYC(FILT_CYC)
	) u_filter (
		.mclk_i     (mclk_i),
		.nrst_i     (nrst_i),
		.raw_i      (zc_cmp_i),
		.sample_en_i(sample_en),
		.restart_i  (commutate_i),
		.preset_i   (!rising),
		.filt_o     (filt_level)
	);

	// Rising crossing ends high, falling ends low
	assign zc_detect = !st.zc_seen && !commutate_i && filt_level == rising;

	always_comb begin
		// Stale crossing state must not leak into the new period
		if (rising) begin
			mixed_side = (st.zc_seen && !commutate_i) ? brs_pkg::SIDE_LOW : brs_pkg::SIDE_HIGH;
		end else begin
			mixed_side = (st.zc_seen && !commutate_i) ? brs_pkg::SIDE_HIGH : brs_pkg::SIDE_LOW;
		end
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		next_st          = st;
		next_st.mode     = recirc_path_select_i;
		next_st.zc_pulse = zc_detect;
		if (commutate_i) begin
			next_st.zc_seen = 1'b0;
			next_st.degauss = 1'b1;
		end else begin
			if (zc_detect) begin
				next_st.zc_seen = 1'b1;
			end
			if (!rail_clamp_i) begin
				next_st.degauss = 1'b0;
			end
		end
		case (st.mode)
			`BRS_RM_LOW:    next_st.side = brs_pkg::SIDE_LOW;
			`BRS_RM_HIGH:   next_st.side = brs_pkg::SIDE_HIGH;
			`BRS_RM_MIXED:  next_st.side = mixed_side;
			`BRS_RM_NONSYNC: next_st.side = brs_pkg::SIDE_NONE;
			default:        next_st.side = brs_pkg::SIDE_NONE;
		endcase
		if (pwm_on_i) begin
			next_st.gate.high = ph.hi;
			next_st.gate.low  = ph.lo;
		end else begin
			case (next_st.side)
				brs_pkg::SIDE_LOW: begin
					next_st.gate.high = 3'h0;
					next_st.gate.low  = ph.hi | ph.lo;
				end
				brs_pkg::SIDE_HIGH: begin
					next_st.gate.high = ph.hi | ph.lo;
					next_st.gate.low  = 3'h0;
				end
				brs_pkg::SIDE_NONE: begin
					next_st.gate = '0;
				end
				default: begin
					next_st.gate = '0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st      <= '0;
			st.mode <= `BRS_RM_RESET;
			st.side <= brs_pkg::SIDE_NONE;
		end else begin
			st <= next_st;
		end
	end

	assign gate_high_o   = st.gate.high;
	assign gate_low_o    = st.gate.low;
	assign zc_event_o    = st.zc_pulse;
	assign recirc_high_o = st.side == brs_pkg::SIDE_HIGH;
	assign recirc_low_o  = st.side == brs_pkg::SIDE_LOW;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	sequence seq_off_in_mode(logic [1:0] m);
		!pwm_on_i && recirc_path_select_i == m && st.mode == m;
	endsequence

	sequence seq_falling_before_zc;
		st.mode == `BRS_RM_MIXED && !pwm_on_i && !st.zc_seen && !zc_detect && !commutate_i && !rising
			&& step_i < 3'h6;
	endsequence

	chk_float_undriven: assert property (
		1'b1 |=> ((gate_high_o | gate_low_o) & $past(ph.fl)) == 3'h0)
		else $error("Floating phase was driven");

	chk_on_drive: assert property (
		pwm_on_i |=> gate_high_o == $past(ph.hi) && gate_low_o == $past(ph.lo))
		else $error("On-time drive pattern wrong");

	chk_low_recirc: assert property (seq_off_in_mode(`BRS_RM_LOW)
		|=> gate_high_o == 3'h0 && gate_low_o == $past(ph.hi | ph.lo))
		else $error("Low-side recirculation not applied");

	chk_high_recirc: assert property (seq_off_in_mode(`BRS_RM_HIGH)
		|=> gate_low_o == 3'h0 && gate_high_o == $past(ph.hi | ph.lo))
		else $error("High-side recirculation not applied");

	chk_nonsync_off: assert property (seq_off_in_mode(`BRS_RM_NONSYNC)
		|=> gate_high_o == 3'h0 && gate_low_o == 3'h0)
		else $error("Transistor on in non-synchronous off-time");

	chk_mixed_falling: assert property (seq_falling_before_zc
		|=> gate_high_o == 3'h0 && gate_low_o != 3'h0)
		else $error("Mixed mode falling period not low-side");

	chk_mixed_rising: assert property (
		st.mode == `BRS_RM_MIXED && !pwm_on_i && !st.zc_seen && !zc_detect && !commutate_i && rising
			&& step_i < 3'h6
		|=> gate_low_o == 3'h0 && gate_high_o != 3'h0)
		else $error("Mixed mode rising period not high-side");

	chk_zc_flip: assert property (
		$rose(st.zc_seen) |-> zc_event_o && $past(filt_level) == $past(rising))
		else $error("Crossing state changed without filtered event");

	chk_commut_restore: assert property (
		commutate_i |=> !st.zc_seen ##1 !zc_event_o)
		else $error("Commutation did not restore start side");

	chk_degauss_blank: assert property (
		degauss_comp_enable_i && commutate_i |=> st.degauss && !sample_en)
		else $error("Comparator sampled during degauss");

	chk_reset_mode: assert property (disable iff (1'b0)
		!nrst_i |=> st.mode == `BRS_RM_MIXED && gate_high_o == 3'h0 && gate_low_o == 3'h0)
		else $error("Mode field not mixed after reset");

endmodule

// file: hdl/brs_cfg.svh
`ifndef BRS_CFG_SVH
`define BRS_CFG_SVH

// Recirculation mode field encodings
`define BRS_RM_MIXED      2'h0
`define BRS_RM_HIGH       2'h1
`define BRS_RM_LOW        2'h2
`define BRS_RM_NONSYNC    2'h3
`define BRS_RM_RESET      2'h0

// Clock and zero-crossing filter timing
`define BRS_CLK_PERIOD_NS 4
`define BRS_ZC_FILT_NS    100
`define BRS_ZC_FILT_CYC   ((`BRS_ZC_FILT_NS + `BRS_CLK_PERIOD_NS - 1) / `BRS_CLK_PERIOD_NS)

// Commutation steps and filter counter width
`define BRS_STEP_COUNT    3'h6
`define BRS_FILT_CNT_W    8

`endif

// file: hdl/brs_pkg.sv
package brs_pkg;

	typedef enum logic [1:0] {
		SIDE_LOW,
		SIDE_HIGH,
		SIDE_NONE
	} brs_side_t;

	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
		logic [2:0] fl;
	} brs_phase_t;

	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} brs_gate_t;

	typedef struct packed {
		logic       filt;
		logic [7:0] cnt;
	} brs_filt_state_t;

	typedef struct packed {
		logic [1:0] mode;
		logic       zc_seen;
		logic       degauss;
		logic       zc_pulse;
		brs_side_t  side;
		brs_gate_t  gate;
	} brs_state_t;

endpackage

// file: hdl/brs_zc_filter.sv
`timescale 1ns/10ps
`include "brs_cfg.svh"

module brs_zc_filter #(
	parameter int FILT_CYC = `BRS_ZC_FILT_CYC
) (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic raw_i,
	input  wire logic sample_en_i,
	input  wire logic restart_i,
	input  wire logic preset_i,
	output logic      filt_o
);

	brs_pkg::brs_filt_state_t st;
	brs_pkg::brs_filt_state_t next_st;

	////////////////////////////////////////////////////////////////
	// Level changes only on a restart preset or after FILT_CYC agreeing samples
	always_comb begin
		next_st = st;
		if (restart_i) begin
			next_st.filt = preset_i;
			next_st.cnt  = '0;
		end else if (sample_en_i) begin
			if (raw_i == st.filt) begin
				next_st.cnt = '0;
			end else if (st.cnt == 8'(FILT_CYC - 1)) begin
				next_st.filt = raw_i;
				next_st.cnt  = '0;
			end else begin
				next_st.cnt = st.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign filt_o = st.filt;

	////////////////////////////////////////////////////////////////
	chk_filter_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!restart_i && $past(nrst_i) && !$past(restart_i) && $changed(st.filt)
		|-> $past(st.cnt) == 8'(FILT_CYC - 1) && st.filt == $past(raw_i))
		else $error("Filtered level changed without a full agreeing run");

endmodule

// file: tb/brs_bridge_model.sv
`timescale 1ns/10ps
module brs_bridge_model (
	input  wire logic       mclk_i,
	input  wire logic       commutate_i,
	input  wire logic       rising_i,
	input  wire logic       crossed_i,
	input  wire logic [4:0] clamp_len_i,
	output logic            zc_cmp_o,
	output logic            rail_clamp_o
);
	logic [4:0] left;
	initial left = 5'h00;
	// Floating phase crosses the center tap
	assign zc_cmp_o = crossed_i ? rising_i : !rising_i;
	// Winding holds the floating phase at a rail after commutation
	always @(posedge mclk_i) begin
		if (commutate_i) begin
			left <= clamp_len_i;
		end else if (left != 5'h00) begin
			left <= left - 5'h01;
		end
	end
	assign rail_clamp_o = commutate_i | (left != 5'h00);
endmodule

// file: tb/brs_recirc_select_tb.sv
`timescale 1ns/10ps
module brs_recirc_select_tb;
	logic       mclk_i, nrst_i, degauss_comp_enable, comm_p, pwm_on, zc, clamp, crossed, zc_ev, rh, rl;
	logic [1:0] mode;
	logic [2:0] step, gh, gl;
	logic [4:0] clamp_len;
	int         fails, comparisons, seed, i;
	bit         seen;
	brs_recirc_select #(.FILT_CYC(3)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.recirc_path_select_i(mode), .degauss_comp_enable_i(degauss_comp_enable), .commutate_i(comm_p),
		.step_i(step), .pwm_on_i(pwm_on), .zc_cmp_i(zc), .rail_clamp_i(clamp),
		.gate_high_o(gh), .gate_low_o(gl), .zc_event_o(zc_ev), .recirc_high_o(rh),
		.recirc_low_o(rl));
	brs_bridge_model bridge (.mclk_i(mclk_i), .commutate_i(comm_p), .rising_i(step[0]),
		.crossed_i(crossed), .clamp_len_i(clamp_len), .zc_cmp_o(zc), .rail_clamp_o(clamp));
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	////////////////////////////////////////////////////////////////
	// Expected gates as {high, low}
	function automatic logic [5:0] on_g(input logic [2:0] s);
		case (s)
			3'h0: on_g = 6'h0A;
			3'h1: on_g = 6'h0C;
			3'h2: on_g = 6'h14;
			3'h3: on_g = 6'h11;
			3'h4: on_g = 6'h21;
			3'h5: on_g = 6'h22;
			default: on_g = 6'h00;
		endcase
	endfunction
	// Side code 1 high, 2 low, else all off
	function automatic logic [5:0] off_g(input logic [2:0] s, input logic [1:0] m);
		logic [5:0] g;
		logic [2:0] a;
		g = on_g(s);
		a = g[5:3] | g[2:0];
		case (m)
			2'h1: off_g = {a, 3'h0};
			2'h2: off_g = {3'h0, a};
			default: off_g = 6'h00;
		endcase
	endfunction
	// Expected {recirc_high, recirc_low} for a side code
	function automatic logic [1:0] side_hl(input logic [1:0] m);
		case (m)
			2'h1: side_hl = 2'h2;
			2'h2: side_hl = 2'h1;
			default: side_hl = 2'h0;
		endcase
	endfunction
	task chk(input string n, input logic [5:0] e, input logic [5:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task comm(input logic [2:0] s);
		cyc(1);
		step = s;
		comm_p = 1'b1;
		crossed = 1'b0;
		cyc(1);
		comm_p = 1'b0;
	endtask
	task wait_zc(input int lim);
		int k;
		seen = 1'b0;
		for (k = 0; k < lim && !seen; k++) begin
			cyc(1);
			seen = (zc_ev === 1'b1);
		end
		if (!seen) begin
			fails++;
			$display("wrong value zc_event expected 1 seen 0");
			tally_and_finish();
		end
	endtask
	task tally_and_finish();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hF7FCDBD4;
		fails = 0;
		comparisons = 0;
		nrst_i = 1'b0;
		degauss_comp_enable = 1'b0;
		comm_p = 1'b0;
		step = 3'h7;
		pwm_on = 1'b0;
		mode = 2'h0;
		crossed = 1'b0;
		clamp_len = 5'h00;
		cyc(4);
		nrst_i = 1'b1;
		cyc(2);
		chk("reset gates", 6'h00, {gh, gl});
		for (i = 0; i < 14; i++) begin
			step = (i < 8) ? 3'(i) : 3'($unsigned($random(seed)) % 6);
			mode = 2'($random(seed));
			if (mode == 2'h0) begin
				mode = 2'h3;
			end
			pwm_on = 1'b1;
			cyc(3);
			chk("on gates", on_g(step), {gh, gl});
			pwm_on = 1'b0;
			cyc(3);
			chk("off gates", off_g(step, mode), {gh, gl});
			chk("recirc side", {4'h0, side_hl(mode)}, {4'h0, rh, rl});
		end
		mode = 2'h0;
		for (i = 0; i < 6; i++) begin
			comm(3'(i));
			chk("mixed restore", off_g(3'(i), i[0] ? 2'h1 : 2'h2), {gh, gl});
			cyc(3);
			chk("mixed start", off_g(3'(i), i[0] ? 2'h1 : 2'h2), {gh, gl});
			chk("mixed side", {4'h0, side_hl(i[0] ? 2'h1 : 2'h2)}, {4'h0, rh, rl});
			crossed = 1'b1;
			wait_zc(12);
			cyc(3);
			chk("mixed after", off_g(3'(i), i[0] ? 2'h2 : 2'h1), {gh, gl});
			chk("mixed side after", {4'h0, side_hl(i[0] ? 2'h2 : 2'h1)}, {4'h0, rh, rl});
		end
		for (i = 0; i < 2; i++) begin
			degauss_comp_enable = (i == 0);
			clamp_len = 5'h0A + 5'($unsigned($random(seed)) % 8);
			comm(3'h1);
			crossed = 1'b1;
			if (degauss_comp_enable) begin
				repeat (8) begin
					cyc(1);
					chk("zc blanked", 6'h00, {5'h00, zc_ev});
				end
			end
			wait_zc(degauss_comp_enable ? 40 : 8);
		end
		tally_and_finish();
	end
endmodule
